// file: hdl/pfs_top.sv
// Function select registers and pin muxing for port 1 pins 4, 5 and 6
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - One 8-bit read/write register per pin 4, 5, 6 at consecutive addresses.
// - Registers read back what was written, bits 5 and 3 of pins 4 and 5 as zero, and clear to zero on reset.
// - Bit 0 enables general-purpose I/O on the pin; clear means disabled.
// - Bit 1 feeds the pin into the first shared pin-interrupt source.
// - Bit 2 feeds the pin into the second shared pin-interrupt source.
// - Several pins may feed one interrupt source; their conditions combine.
// - One pin may feed both interrupt sources at once.
// - Bit 7 enables touch sensing, channels C, D, E for pins 4, 5, 6.
// - Pin 4 bit 6 makes the pin the second I2C target clock line.
// - Pin 5 bit 6 makes the pin the second I2C target data line.
// - Pin 4 bit 4 makes the pin the I2C controller clock line.
// - Pin 5 bit 4 makes the pin the I2C controller data line.
// - Pin 6: bit 6 timer one, 5 controller clock, 4 compare unit, 3 SPI clock.
// - Bits 5 and 3 of the pin 4 and pin 5 registers have no function.
// - Neighbouring pins share layout: bit 0 I/O, bits 1 and 2 interrupts.
module pfs_top
    import pfs_pkg::*;
#(
    parameter int NPINS = NUM_PINS
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [NPINS-1:0] pad_in_i,
    output logic [NPINS-1:0] pad_out_o,
    output logic [NPINS-1:0] pad_oe_o,
    input wire logic [NPINS-1:0] general_io_out_i,
    input wire logic [NPINS-1:0] general_io_oe_i,
    output logic [NPINS-1:0] general_io_in_o,
    output logic touch_channel_c_select_o,
    output logic touch_channel_d_select_o,
    output logic touch_channel_e_select_o,
    input wire logic second_target_clock_low_i,
    input wire logic second_target_data_low_i,
    output logic second_target_clock_o,
    output logic second_target_data_o,
    input wire logic controller_clock_low_i,
    input wire logic controller_data_low_i,
    output logic controller_clock_o,
    output logic controller_data_o,
    output logic timer_one_input_o,
    input wire logic compare_unit0_out_i,
    input wire logic compare_unit0_oe_i,
    output logic compare_unit0_in_o,
    input wire logic serial_periph_clock_out_i,
    input wire logic serial_periph_clock_oe_i,
    output logic serial_periph_clock_in_o,
    output logic pin_irq_a_o,
    output logic pin_irq_b_o
);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] cfg_q [NUM_PINS];
    logic [1:0] wr_idx;
    logic [1:0] rd_idx;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    assign wr_idx = pfs_decode(addr_i);
    assign rd_idx = wr_idx;

    // Masking on write keeps unused bits at zero, so reads need no mask
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
        end else if (wr_i && (wr_idx != IDX_NONE)) begin
            cfg_q[wr_idx] <= wdata_i & pfs_mask(wr_idx);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Data appear only in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_d = RDATA_IDLE;
        if (rd_i && (rd_idx != IDX_NONE)) begin
            rdata_d = cfg_q[rd_idx];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_q <= RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] gio_sel;
    logic [NUM_PINS-1:0] irq_a_route;
    logic [NUM_PINS-1:0] irq_b_route;
    logic [NUM_PINS-1:0] touch_sel;
    logic [NUM_PINS-1:0] tgt_sel;
    logic [NUM_PINS-1:0] tgt_low;
    logic [NUM_PINS-1:0] ctl_sel;
    logic [NUM_PINS-1:0] ctl_low;
    logic [NUM_PINS-1:0] cmp_sel;
    logic [NUM_PINS-1:0] sck_sel;
    logic timer_sel;

    // The low three fields sit alike on every pin of the port
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            gio_sel[i] = cfg_q[i][BIT_GENERAL_IO];
            irq_a_route[i] = cfg_q[i][BIT_IRQ_A_ROUTE];
            irq_b_route[i] = cfg_q[i][BIT_IRQ_B_ROUTE];
            touch_sel[i] = cfg_q[i][BIT_TOUCH];
        end
    end

    // Pin-specific alternate functions
    assign tgt_sel[IDX_PIN4] = cfg_q[IDX_PIN4][BIT_SECOND_TARGET];
    assign tgt_sel[IDX_PIN5] = cfg_q[IDX_PIN5][BIT_SECOND_TARGET];
    assign tgt_sel[IDX_PIN6] = 1'b0;
    assign ctl_sel[IDX_PIN4] = cfg_q[IDX_PIN4][BIT_CONTROLLER];
    assign ctl_sel[IDX_PIN5] = cfg_q[IDX_PIN5][BIT_CONTROLLER];
    assign ctl_sel[IDX_PIN6] = cfg_q[IDX_PIN6][BIT_P6_CONTROLLER_CLK];
    assign cmp_sel[IDX_PIN4] = 1'b0;
    assign cmp_sel[IDX_PIN5] = 1'b0;
    assign cmp_sel[IDX_PIN6] = cfg_q[IDX_PIN6][BIT_P6_COMPARE_UNIT0];
    assign sck_sel[IDX_PIN4] = 1'b0;
    assign sck_sel[IDX_PIN5] = 1'b0;
    assign sck_sel[IDX_PIN6] = cfg_q[IDX_PIN6][BIT_P6_SERIAL_CLK];
    assign timer_sel = cfg_q[IDX_PIN6][BIT_P6_TIMER_ONE];

    // Open-drain pull requests from the two I2C blocks, per pin
    assign tgt_low[IDX_PIN4] = second_target_clock_low_i;
    assign tgt_low[IDX_PIN5] = second_target_data_low_i;
    assign tgt_low[IDX_PIN6] = 1'b0;
    assign ctl_low[IDX_PIN4] = controller_clock_low_i;
    assign ctl_low[IDX_PIN5] = controller_data_low_i;
    assign ctl_low[IDX_PIN6] = controller_clock_low_i;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pad_out_d;
    logic [NUM_PINS-1:0] pad_oe_d;

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        pfs_pin_route u_route (
            .touch_sel_i(touch_sel[g]),
            .tgt_sel_i(tgt_sel[g]),
            .tgt_low_i(tgt_low[g]),
            .ctl_sel_i(ctl_sel[g]),
            .ctl_low_i(ctl_low[g]),
            .cmp_sel_i(cmp_sel[g]),
            .cmp_out_i(compare_unit0_out_i),
            .cmp_oe_i(compare_unit0_oe_i),
            .sck_sel_i(sck_sel[g]),
            .sck_out_i(serial_periph_clock_out_i),
            .sck_oe_i(serial_periph_clock_oe_i),
            .gio_sel_i(gio_sel[g]),
            .gio_out_i(general_io_out_i[g]),
            .gio_oe_i(general_io_oe_i[g]),
            .pad_out_o(pad_out_d[g]),
            .pad_oe_o(pad_oe_d[g])
        );
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
        end else begin
            pad_out_o <= pad_out_d;
            pad_oe_o <= pad_oe_d;
        end
    end

    // ------------------------------------------------------------
    // Peripheral inputs
    // ------------------------------------------------------------
    // Unrouted I2C lines read as released; pin 4 and pin 6 clocks are wired-and
    logic tgt_clk_d;
    logic tgt_dat_d;
    logic ctl_clk_d;
    logic ctl_dat_d;

    assign tgt_clk_d = pfs_od_in(tgt_sel[IDX_PIN4], pad_in_i[IDX_PIN4]);
    assign tgt_dat_d = pfs_od_in(tgt_sel[IDX_PIN5], pad_in_i[IDX_PIN5]);
    assign ctl_clk_d = pfs_od_in(ctl_sel[IDX_PIN4], pad_in_i[IDX_PIN4])
                     & pfs_od_in(ctl_sel[IDX_PIN6], pad_in_i[IDX_PIN6]);
    assign ctl_dat_d = pfs_od_in(ctl_sel[IDX_PIN5], pad_in_i[IDX_PIN5]);

    // Lines read released during reset, so no false start is seen on the bus
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            second_target_clock_o <= 1'b1;
            second_target_data_o <= 1'b1;
        end else begin
            second_target_clock_o <= tgt_clk_d;
            second_target_data_o <= tgt_dat_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            controller_clock_o <= 1'b1;
            controller_data_o <= 1'b1;
        end else begin
            controller_clock_o <= ctl_clk_d;
            controller_data_o <= ctl_dat_d;
        end
    end

    // Other inputs read zero while their function is off
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            general_io_in_o <= '0;
        end else begin
            general_io_in_o <= pad_in_i & gio_sel;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            timer_one_input_o <= 1'b0;
        end else begin
            timer_one_input_o <= timer_sel & pad_in_i[IDX_PIN6];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            compare_unit0_in_o <= 1'b0;
        end else begin
            compare_unit0_in_o <= cmp_sel[IDX_PIN6] & pad_in_i[IDX_PIN6];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            serial_periph_clock_in_o <= 1'b0;
        end else begin
            serial_periph_clock_in_o <= sck_sel[IDX_PIN6] & pad_in_i[IDX_PIN6];
        end
    end

    // ------------------------------------------------------------
    // Touch channel enables
    // ------------------------------------------------------------
    assign touch_channel_c_select_o = cfg_q[IDX_PIN4][BIT_TOUCH];
    assign touch_channel_d_select_o = cfg_q[IDX_PIN5][BIT_TOUCH];
    assign touch_channel_e_select_o = cfg_q[IDX_PIN6][BIT_TOUCH];

    // ------------------------------------------------------------
    // Shared pin-interrupt sources
    // ------------------------------------------------------------
    // Level conditions only; edge or polarity handling lives downstream
    logic irq_a_d;
    logic irq_b_d;

    pfs_irq_combine #(
        .NPINS(NUM_PINS)
    ) u_irq (
        .pin_level_i(pad_in_i),
        .route_a_i(irq_a_route),
        .route_b_i(irq_b_route),
        .irq_a_o(irq_a_d),
        .irq_b_o(irq_b_d)
    );

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pin_irq_a_o <= 1'b0;
        end else begin
            pin_irq_a_o <= irq_a_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pin_irq_b_o <= 1'b0;
        end else begin
            pin_irq_b_o <= irq_b_d;
        end
    end

endmodule : pfs_top
`default_nettype wire

// file: hdl/pfs_pkg.sv
// Constants and decode helpers for the port 1 upper pin function select block
package pfs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int NUM_PINS = 3;
    localparam logic [15:0] ADDR_PIN4 = 16'ha05c;
    localparam logic [15:0] ADDR_PIN5 = 16'ha05d;
    localparam logic [15:0] ADDR_PIN6 = 16'ha05e;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    // Writable bits; bits 5 and 3 of pins 4 and 5 are unused
    localparam logic [7:0] MASK_PIN45 = 8'hd7;
    localparam logic [7:0] MASK_PIN6 = 8'hff;

    // ------------------------------------------------------------
    // Pin indices
    // ------------------------------------------------------------
    localparam int IDX_PIN4 = 0;
    localparam int IDX_PIN5 = 1;
    localparam int IDX_PIN6 = 2;
    localparam logic [1:0] IDX_NONE = 2'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_GENERAL_IO = 0;
    localparam int BIT_IRQ_A_ROUTE = 1;
    localparam int BIT_IRQ_B_ROUTE = 2;
    localparam int BIT_TOUCH = 7;
    localparam int BIT_SECOND_TARGET = 6;
    localparam int BIT_CONTROLLER = 4;
    localparam int BIT_P6_TIMER_ONE = 6;
    localparam int BIT_P6_CONTROLLER_CLK = 5;
    localparam int BIT_P6_COMPARE_UNIT0 = 4;
    localparam int BIT_P6_SERIAL_CLK = 3;

    // Address decode, used by both the write and the read path
    function automatic logic [1:0] pfs_decode(input logic [15:0] addr);
        logic [1:0] idx;
        idx = IDX_NONE;
        if (addr == ADDR_PIN4) begin
            idx = 2'(IDX_PIN4);
        end else if (addr == ADDR_PIN5) begin
            idx = 2'(IDX_PIN5);
        end else if (addr == ADDR_PIN6) begin
            idx = 2'(IDX_PIN6);
        end
        return idx;
    endfunction : pfs_decode

    // Writable mask of one pin register
    function automatic logic [7:0] pfs_mask(input logic [1:0] idx);
        return (idx == 2'(IDX_PIN6)) ? MASK_PIN6 : MASK_PIN45;
    endfunction : pfs_mask

    // Input seen by an open-drain peripheral: released high when not routed
    function automatic logic pfs_od_in(input logic sel, input logic pad);
        return sel ? pad : 1'b1;
    endfunction : pfs_od_in

endpackage : pfs_pkg

// file: hdl/pfs_pin_route.sv
// Output driver selection for one multi-function pin
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_route (
    input wire logic touch_sel_i,
    input wire logic tgt_sel_i,
    input wire logic tgt_low_i,
    input wire logic ctl_sel_i,
    input wire logic ctl_low_i,
    input wire logic cmp_sel_i,
    input wire logic cmp_out_i,
    input wire logic cmp_oe_i,
    input wire logic sck_sel_i,
    input wire logic sck_out_i,
    input wire logic sck_oe_i,
    input wire logic gio_sel_i,
    input wire logic gio_out_i,
    input wire logic gio_oe_i,
    output logic pad_out_o,
    output logic pad_oe_o
);

    // ------------------------------------------------------------
    // Fixed priority
    // ------------------------------------------------------------
    // Touch sensing is analog, so it silences every digital driver
    always_comb begin
        pad_out_o = 1'b0;
        pad_oe_o = 1'b0;
        if (touch_sel_i) begin
            pad_oe_o = 1'b0;
        end else if (tgt_sel_i) begin
            pad_oe_o = tgt_low_i;
        end else if (ctl_sel_i) begin
            pad_oe_o = ctl_low_i;
        end else if (cmp_sel_i) begin
            pad_out_o = cmp_out_i;
            pad_oe_o = cmp_oe_i;
        end else if (sck_sel_i) begin
            pad_out_o = sck_out_i;
            pad_oe_o = sck_oe_i;
        end else if (gio_sel_i) begin
            pad_out_o = gio_out_i;
            pad_oe_o = gio_oe_i;
        end
    end

endmodule : pfs_pin_route
`default_nettype wire

// file: hdl/pfs_irq_combine.sv
// Combines routed pin levels into the two shared pin-interrupt sources
`timescale 1ns/1ps
`default_nettype none
module pfs_irq_combine #(
    parameter int NPINS = 3
) (
    input wire logic [NPINS-1:0] pin_level_i,
    input wire logic [NPINS-1:0] route_a_i,
    input wire logic [NPINS-1:0] route_b_i,
    output logic irq_a_o,
    output logic irq_b_o
);

    // ------------------------------------------------------------
    // Wired-or of every routed pin
    // ------------------------------------------------------------
    // A pin routed to both sources simply appears in both sums
    assign irq_a_o = |(pin_level_i & route_a_i);
    assign irq_b_o = |(pin_level_i & route_b_i);

endmodule : pfs_irq_combine
`default_nettype wire

// file: bench/pfs_pad_model.sv
// Pad and external line model for the three multi-function pins
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model (
    input wire logic [2:0] pad_out_i,
    input wire logic [2:0] pad_oe_i,
    input wire logic [2:0] ext_drv_i,
    input wire logic [2:0] ext_val_i,
    output logic [2:0] pad_lvl_o
);
    // Any low driver wins; a released line rises on its pull-up
    assign pad_lvl_o = ~((pad_oe_i & ~pad_out_i) | (ext_drv_i & ~ext_val_i));
endmodule : pfs_pad_model
`default_nettype wire

// file: bench/pfs_top_assertions.sv
// Concurrent checks on the pin function select ports
`timescale 1ns/1ps
`default_nettype none
module pfs_top_checker
    import pfs_pkg::*;
#(
    parameter int NPINS = NUM_PINS
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [NPINS-1:0] pad_in_i,
    input wire logic [NPINS-1:0] pad_out_o,
    input wire logic [NPINS-1:0] pad_oe_o,
    input wire logic [NPINS-1:0] general_io_in_o,
    input wire logic touch_channel_c_select_o,
    input wire logic touch_channel_d_select_o,
    input wire logic touch_channel_e_select_o,
    input wire logic second_target_clock_low_i,
    input wire logic controller_data_o,
    input wire logic timer_one_input_o,
    input wire logic pin_irq_a_o,
    input wire logic pin_irq_b_o
);
    // Shadow of the registers, rebuilt from bus traffic
    logic [7:0] sh_q [3];
    logic [7:0] rexp;
    logic [2:0] ia, ib, gs, ts;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sh_q <= '{default: 8'h00};
        end else if (wr_i) begin
            if (addr_i == ADDR_PIN4) sh_q[0] <= wdata_i & MASK_PIN45;
            if (addr_i == ADDR_PIN5) sh_q[1] <= wdata_i & MASK_PIN45;
            if (addr_i == ADDR_PIN6) sh_q[2] <= wdata_i;
        end
    end
    always_comb begin
        rexp = 8'h00;
        if (addr_i == ADDR_PIN4) rexp = sh_q[0];
        if (addr_i == ADDR_PIN5) rexp = sh_q[1];
        if (addr_i == ADDR_PIN6) rexp = sh_q[2];
    end
    assign ia = pad_in_i & {sh_q[2][1], sh_q[1][1], sh_q[0][1]};
    assign ib = pad_in_i & {sh_q[2][2], sh_q[1][2], sh_q[0][2]};
    assign gs = pad_in_i & {sh_q[2][0], sh_q[1][0], sh_q[0][0]};
    assign ts = {sh_q[2][7], sh_q[1][7], sh_q[0][7]};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_read_cmd;
        rd_i && !wr_i;
    endsequence
    sequence s_tgt_clk_sel;
        sh_q[0][7:6] == 2'h1;
    endsequence
    a_read_data: assert property (s_read_cmd |=> rdata_o == $past(rexp))
        else $error("read data differs from register");
    a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    a_touch_sel: assert property (
        {touch_channel_e_select_o, touch_channel_d_select_o, touch_channel_c_select_o} == ts)
        else $error("touch select mismatch");
    a_irq_a_or: assert property (1'b1 |=> pin_irq_a_o == $past(|ia))
        else $error("first pin interrupt wrong");
    a_irq_b_or: assert property (1'b1 |=> pin_irq_b_o == $past(|ib))
        else $error("second pin interrupt wrong");
    a_gio_input: assert property (1'b1 |=> general_io_in_o == $past(gs))
        else $error("general input path wrong");
    a_timer_input: assert property (
        1'b1 |=> timer_one_input_o == $past(pad_in_i[2] & sh_q[2][6]))
        else $error("timer input path wrong");
    a_ctl_data: assert property (!sh_q[1][4] |=> controller_data_o)
        else $error("unrouted controller data not high");
    a_tgt_clk_od: assert property (
        s_tgt_clk_sel |=> !pad_out_o[0] && pad_oe_o[0] == $past(second_target_clock_low_i))
        else $error("target clock drive wrong");
endmodule : pfs_top_checker
bind pfs_top pfs_top_checker #(.NPINS(NPINS)) i_chk (.mclk_i, .reset_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .general_io_in_o,
    .touch_channel_c_select_o, .touch_channel_d_select_o, .touch_channel_e_select_o,
    .second_target_clock_low_i, .controller_data_o, .timer_one_input_o,
    .pin_irq_a_o, .pin_irq_b_o);
`default_nettype wire

// file: bench/tb.sv
// Register and pin path testbench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfs_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [2:0] gio_out = 3'h0, gio_oe = 3'h0, ext_drv = 3'h0, ext_val = 3'h0;
    logic st_cl = 1'b0, st_dl = 1'b0, ct_cl = 1'b0, ct_dl = 1'b0;
    logic cmp_out = 1'b0, cmp_oe = 1'b0, sck_out = 1'b0, sck_oe = 1'b0;
    logic [7:0] rdata;
    logic [2:0] pad_in, pad_out, pad_oe, gio_in;
    logic tc, td, te, st_c, st_d, ct_c, ct_d, tmr, cmp_in, sck_in, irq_a, irq_b;
    logic [2:0] iv [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
    logic [1:0] ie [4] = '{2'h0, 2'h1, 2'h3, 2'h1};
    int mismatches = 0, n_tests = 0, cycles = 0;

    pfs_top #(.NPINS(3)) i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .general_io_out_i(gio_out),
        .general_io_oe_i(gio_oe), .general_io_in_o(gio_in), .touch_channel_c_select_o(tc),
        .touch_channel_d_select_o(td), .touch_channel_e_select_o(te),
        .second_target_clock_low_i(st_cl), .second_target_data_low_i(st_dl),
        .second_target_clock_o(st_c), .second_target_data_o(st_d),
        .controller_clock_low_i(ct_cl), .controller_data_low_i(ct_dl),
        .controller_clock_o(ct_c), .controller_data_o(ct_d), .timer_one_input_o(tmr),
        .compare_unit0_out_i(cmp_out), .compare_unit0_oe_i(cmp_oe),
        .compare_unit0_in_o(cmp_in), .serial_periph_clock_out_i(sck_out),
        .serial_periph_clock_oe_i(sck_oe), .serial_periph_clock_in_o(sck_in),
        .pin_irq_a_o(irq_a), .pin_irq_b_o(irq_b));
    pfs_pad_model i_pads (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_drv_i(ext_drv),
        .ext_val_i(ext_val), .pad_lvl_o(pad_in));

    always #50 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk
    // Pin paths are registered, so give them a few edges
    task automatic settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // A hung handshake must not stall the run forever
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1 chk({2'h0, tc, td, te, st_c, ct_c, irq_a}, 8'h06);
        for (int i = 0; i < 3; i++) rd_chk(ADDR_PIN4 + 16'(i), 8'h00);
        for (int i = 0; i < 3; i++) wr_reg(ADDR_PIN4 + 16'(i), 8'hff);
        for (int i = 0; i < 3; i++) rd_chk(ADDR_PIN4 + 16'(i), i == 2 ? 8'hff : 8'hd7);
        chk({5'h0, te, td, tc}, 8'h07);
        wr_reg(16'ha05b, 8'h55);
        wr_reg(16'ha05f, 8'h55);
        rd_chk(16'ha05b, 8'h00);
        rd_chk(ADDR_PIN5, 8'hd7);
        // General I/O: pin 5 driven low, pin 6 left to its pull-up
        for (int i = 0; i < 3; i++) wr_reg(ADDR_PIN4 + 16'(i), 8'h01);
        gio_out <= 3'h5;
        gio_oe <= 3'h3;
        settle();
        chk({5'h0, pad_oe}, 8'h03);
        chk({5'h0, pad_out & pad_oe, gio_in}, 8'h0d);
        wr_reg(ADDR_PIN5, 8'h00);
        settle();
        chk({5'h0, pad_oe}, 8'h01);
        // Shared interrupts: pins 4, 5 on the first source, pin 6 on both
        wr_reg(ADDR_PIN4, 8'h02);
        wr_reg(ADDR_PIN5, 8'h02);
        wr_reg(ADDR_PIN6, 8'h06);
        gio_oe <= 3'h0;
        ext_drv <= 3'h7;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            ext_val <= iv[i];
            settle();
            chk({6'h0, irq_b, irq_a}, {6'h0, ie[i]});
        end
        // I2C target lines, then controller lines with target priority
        wr_reg(ADDR_PIN4, 8'h40);
        wr_reg(ADDR_PIN5, 8'h40);
        ext_drv <= 3'h0;
        st_cl <= 1'b1;
        settle();
        chk({4'h0, pad_oe[1:0], st_d, st_c}, 8'h06);
        wr_reg(ADDR_PIN4, 8'h50);
        wr_reg(ADDR_PIN5, 8'h10);
        st_cl <= 1'b0;
        ct_cl <= 1'b1;
        ct_dl <= 1'b1;
        settle();
        chk({3'h0, pad_oe[1:0], ct_d, ct_c, st_c}, 8'h13);
        wr_reg(ADDR_PIN4, 8'h10);
        settle();
        chk({5'h0, pad_oe[0], ct_c, st_c}, 8'h05);
        // Pin 6 functions one at a time
        wr_reg(ADDR_PIN6, 8'h40);
        ext_drv <= 3'h4;
        ext_val <= 3'h4;
        settle();
        chk({5'h0, tmr, cmp_in, sck_in}, 8'h04);
        wr_reg(ADDR_PIN6, 8'h10);
        ext_drv <= 3'h0;
        cmp_oe <= 1'b1;
        settle();
        chk({5'h0, pad_oe[2], cmp_in, tmr}, 8'h04);
        wr_reg(ADDR_PIN6, 8'h08);
        sck_oe <= 1'b1;
        sck_out <= 1'b1;
        settle();
        chk({5'h0, pad_oe[2], sck_in, cmp_in}, 8'h06);
        wr_reg(ADDR_PIN4, 8'h00);
        wr_reg(ADDR_PIN6, 8'h20);
        settle();
        chk({6'h0, pad_oe[2], ct_c}, 8'h02);
        // Reset in mid-run, then the pin 6 register must read back zero
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd_chk(ADDR_PIN6, 8'h00);
        end_sim();
    end
endmodule : tb
`default_nettype wire
